//--- bench/sn_sleep_monitor.sv
// checker for the serial-number and sleep command block
// sees only the top ports; bound to every instance below
module sn_sleep_monitor #(
    parameter int hib_exit_cycles = sn_sleep_pkg::hibernate_exit_cycles_doc
) (
    // system
    input wire logic                      clk,
    input wire logic                      rst_b,
    // watched pins and status
    input wire sn_sleep_pkg::spi_in_type  spi_in,
    input wire sn_sleep_pkg::spi_out_type spi_out,
    input wire logic                      asleep,
    input wire logic [63:0]               board_serial_number
);
    timeunit 1ns;
    timeprecision 1ns;
    // ====================
    // wake timer
    // counts from the raw select, a few cycles ahead of the synchroniser
    localparam int wake_max = 20 + (hib_exit_cycles > sn_sleep_pkg::deep_sleep_exit_cycles ?
        hib_exit_cycles : sn_sleep_pkg::deep_sleep_exit_cycles);
    int wake_cnt;
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b)
            wake_cnt <= 0;
        else if (!asleep)
            wake_cnt <= 0;
        else if (!spi_in.cs_b || wake_cnt != 0)
            wake_cnt <= wake_cnt + 1;
    end
    // ====================
    // assertions
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_b);
    sequence wake_start;
        asleep && $fell(spi_in.cs_b);
    endsequence
    so_quiet_a: assert property (asleep |-> !spi_out.so_oe)
        else $error("so driven while asleep");
    so_park_a: assert property (!spi_out.so_oe |-> !spi_out.so)
        else $error("so not parked low while released");
    oe_release_a: assert property (spi_in.cs_b [*6] |-> !spi_out.so_oe)
        else $error("so still driven after deselect");
    sn_frame_a: assert property ((!spi_in.cs_b) [*6] |-> $stable(board_serial_number))
        else $error("serial number changed inside a frame");
    sn_sleep_a: assert property (asleep |-> $stable(board_serial_number))
        else $error("serial number changed while asleep");
    sleep_start_a: assert property ($rose(asleep) |-> spi_in.cs_b && $past(spi_in.cs_b))
        else $error("sleep entered without a deselect");
    wake_hold_a: assert property (wake_start |-> asleep [*8])
        else $error("woke without exit delay");
    wake_bound_a: assert property (wake_cnt <= wake_max)
        else $error("wake took too long");
endmodule

bind sn_sleep sn_sleep_monitor #(.hib_exit_cycles(hib_exit_cycles)) u_sn_sleep_monitor (
    .clk(clk), .rst_b(rst_b), .spi_in(spi_in), .spi_out(spi_out),
    .asleep(asleep), .board_serial_number(board_serial_number));

//--- bench/sn_sleep_tb.sv
// self-checking bench for the serial-number and sleep block
// assumes the host model and checker files are compiled first
module sn_sleep_tb;
    timeunit 1ns;
    timeprecision 1ns;
    localparam int hib_cycles = 20;
    logic                      clk = 1'b0;
    logic                      rst_b = 1'b0;
    sn_sleep_pkg::spi_in_type  spi_in;
    sn_sleep_pkg::spi_out_type spi_out;
    logic                      asleep;
    logic [63:0]               board_serial_number;
    logic [127:0]              exp_q[$];
    string                     nm_q[$];
    int                        n_fail = 0;
    int                        n_tests = 0;
    integer                    seed = 32'he187;
    logic [63:0]               sn;
    logic [135:0]              rx;
    always #25 clk = ~clk;
    sn_sleep #(.hib_exit_cycles(hib_cycles)) u_sn_sleep (.clk(clk), .rst_b(rst_b),
        .spi_in(spi_in), .spi_out(spi_out), .asleep(asleep),
        .board_serial_number(board_serial_number));
    spi_host_model u_spi_host_model (.clk(clk), .spi_in(spi_in), .spi_out(spi_out));
    // ====================
    // notes and checks
    function automatic logic [63:0] swap(input logic [63:0] v);
        for (int k = 0; k < 8; k++) swap[63-8*k -: 8] = v[8*k +: 8];
    endfunction
    // crc-8, polynomial 07h, over the seven upper bytes
    function automatic logic [7:0] crc8(input logic [55:0] d);
        logic [7:0] c;
        c = 8'h00;
        for (int k = 55; k >= 0; k--) begin
            c = {c[6:0], 1'b0} ^ ((c[7] ^ d[k]) ? 8'h07 : 8'h00);
        end
        return c;
    endfunction
    // the driver notes only what it expects; the watcher reads the outputs itself
    task automatic note(input string n, input logic [127:0] e);
        nm_q.push_back(n);
        exp_q.push_back(e);
    endtask
    task automatic miss(input string n, input logic [127:0] e, input logic [127:0] o);
        n_fail++;
        $display("unexpected %s: expected %h seen %h", n, e, o);
    endtask
    task automatic cmp_word(input string n, input logic [63:0] e, input logic [63:0] o);
        n_tests++;
        if (o !== e) begin
            miss(n, 128'(e), 128'(o));
        end
    endtask
    task automatic cmp_flag(input string n, input logic e, input logic o);
        n_tests++;
        if (o !== e) begin
            miss(n, 128'(e), 128'(o));
        end
    endtask
    task automatic cmp_stream(input string n, input logic [127:0] e, input logic [127:0] o);
        n_tests++;
        if (o !== e) begin
            miss(n, e, o);
        end
    endtask
    initial forever begin
        wait (exp_q.size() > 0);
        case (nm_q[0])
            "serial": cmp_word(nm_q[0], exp_q[0][63:0], board_serial_number);
            "asleep": cmp_flag(nm_q[0], exp_q[0][0], asleep);
            "so_oe":  cmp_flag(nm_q[0], exp_q[0][0], spi_out.so_oe);
            default:  cmp_stream(nm_q[0], exp_q[0], rx[127:0]);
        endcase
        nm_q.delete(0);
        exp_q.delete(0);
    end
    task automatic conclude();
        $display("comparisons %0d mismatches %0d", n_tests, n_fail);
        if (n_fail == 0 && n_tests > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask
    // ====================
    // host operations
    task automatic cmd(input logic [7:0] op);
        u_spi_host_model.xfer({op, 128'h0}, 8, rx);
    endtask
    task automatic prog(input logic [63:0] v, input int nb);
        u_spi_host_model.xfer({sn_sleep_pkg::serial_id_program_cmd, swap(v), 64'h0}, 8 + 8 * nb, rx);
    endtask
    task automatic fetch(input logic [63:0] v);
        u_spi_host_model.xfer({sn_sleep_pkg::serial_id_fetch_cmd, 128'h0}, 136, rx);
        note("fetch", {swap(v), swap(v)});
    endtask
    task automatic snooze(input logic [7:0] op);
        cmd(op);
        repeat (60) @(posedge clk);
        note("asleep", 128'h1);
    endtask
    // ====================
    // scenarios
    initial begin
        repeat (3) @(posedge clk);
        rst_b <= 1'b1;
        repeat (2) @(posedge clk);
        note("serial", 128'(sn_sleep_pkg::sn_reset));
        fetch(64'h0);
        // customer id and unique number at random, their crc in the low byte
        sn[63:8] = {$random(seed), 24'($random(seed))};
        sn[7:0] = crc8(sn[63:8]);
        prog(sn, 8);
        note("serial", 128'h0);
        cmd(sn_sleep_pkg::write_permit_cmd);
        prog(sn, 7);
        note("serial", 128'h0);
        prog(sn, 8);
        note("serial", 128'(sn));
        fetch(sn);
        $display("serial number test done");
        snooze(sn_sleep_pkg::deep_sleep_cmd);
        u_spi_host_model.pulse();
        note("asleep", 128'h1);
        note("so_oe", 128'h0);
        repeat (250) @(posedge clk);
        note("asleep", 128'h0);
        fetch(sn);
        $display("deep sleep test done");
        snooze(sn_sleep_pkg::hibernate_cmd);
        note("so_oe", 128'h0);
        cmd(8'h00);
        note("asleep", 128'h0);
        fetch(sn);
        $display("hibernate test done");
        wait (exp_q.size() == 0);
        @(posedge clk);
        conclude();
    end
    initial begin
        #1_000_000;
        n_fail++;
        conclude();
    end
endmodule

//--- bench/spi_host_model.sv
// host spi controller model, mode 0, sck period 8 clk (400 ns)
// assumes pins are sampled by the device's own clock
module spi_host_model (
    // system
    input  wire logic                      clk,
    // spi pins
    output      sn_sleep_pkg::spi_in_type  spi_in,
    input  wire sn_sleep_pkg::spi_out_type spi_out
);
    timeunit 1ns;
    timeprecision 1ns;
    initial spi_in = '{cs_b: 1'b1, sck: 1'b0, si: 1'b0};
    // no pull on si: keep it moving between frames so nothing leans on a stale level
    always @(posedge clk) if (spi_in.cs_b) spi_in.si <= ~spi_in.si;
    // ====================
    // one frame: nbits from tx msb down, so sampled mid high phase
    task automatic xfer(input logic [135:0] tx, input int nbits, output logic [135:0] rx);
        rx = '0;
        @(posedge clk) spi_in.cs_b <= 1'b0;
        for (int i = 0; i < nbits; i++) begin
            repeat (2) @(posedge clk);
            spi_in.si <= tx[135-i];
            repeat (2) @(posedge clk);
            spi_in.sck <= 1'b1;
            repeat (2) @(posedge clk);
            rx = {rx[134:0], spi_out.so};
            repeat (2) @(posedge clk);
            spi_in.sck <= 1'b0;
        end
        repeat (4) @(posedge clk);
        spi_in.cs_b <= 1'b1;
        repeat (8) @(posedge clk);
    endtask
    // bare select toggle, sck and si left alone
    task automatic pulse();
        @(posedge clk) spi_in.cs_b <= 1'b0;
        repeat (3) @(posedge clk);
        spi_in.cs_b <= 1'b1;
        repeat (8) @(posedge clk);
    endtask
endmodule

//--- logic/sn_sleep.sv
// spi command slice for the board serial number and the two sleep states
// assumes spi mode 0 or 3 with sck far slower than clk; pins are raw asynchronous inputs
module sn_sleep #(
    parameter int hib_exit_cycles = sn_sleep_pkg::hibernate_exit_cycles_doc
) (
    // system
    input  wire logic                      clk,
    input  wire logic                      rst_b,
    // spi pins
    input  wire sn_sleep_pkg::spi_in_type  spi_in,
    output      sn_sleep_pkg::spi_out_type spi_out,
    // status
    output      logic                      asleep,
    output      logic [63:0]               board_serial_number
);

    // the wake timer is 16 bits wide
    if (hib_exit_cycles < 1 || hib_exit_cycles > 65535) begin : g_bad_hib_exit
        $error("hib_exit_cycles out of range");
    end

    typedef struct packed {
        sn_sleep_pkg::spi_in_type  sync1;
        sn_sleep_pkg::spi_in_type  sync2;
        sn_sleep_pkg::spi_in_type  prev;
        sn_sleep_pkg::power_type   power;
        sn_sleep_pkg::phase_type   phase;
        logic [15:0]               timer;
        logic [7:0]                shift;
        logic [2:0]                bit_cnt;
        logic [2:0]                byte_cnt;
        logic                      write_permit;
        logic                      got_dpd;
        logic                      got_hib;
        logic                      prog_full;
        logic [63:0]               staged;
        logic [63:0]               board_serial_number;
        logic                      so;
        logic                      so_oe;
        logic                      asleep;
    } state_type;

    state_type cur;
    state_type next_cur;

    logic cs_b;
    logic sck_rise;
    logic sck_fall;
    logic cs_rise;
    logic cs_fall;
    logic [7:0] shifted;
    logic [7:0] fetch_byte;

    // pick byte n of the serial number, byte 0 being the least significant
    function automatic logic [7:0] sn_byte(input logic [63:0] sn, input logic [2:0] n);
        sn_byte = sn[{n, 3'b000} +: 8];
    endfunction

    always_comb begin
        next_cur = cur;
        // only sync2 is read past the synchroniser
        next_cur.sync1 = spi_in;
        next_cur.sync2 = cur.sync1;
        next_cur.prev  = cur.sync2;
        cs_b     = cur.sync2.cs_b;
        sck_rise = !cs_b && cur.sync2.sck && !cur.prev.sck;
        sck_fall = !cs_b && !cur.sync2.sck && cur.prev.sck;
        cs_rise  = cs_b && !cur.prev.cs_b;
        cs_fall  = !cs_b && cur.prev.cs_b;
        shifted  = {cur.shift[6:0], cur.sync2.si};
        fetch_byte = sn_byte(cur.board_serial_number, cur.byte_cnt);

        // ====================================================================
        // power states
        unique case (cur.power)
            sn_sleep_pkg::st_awake: begin
                // frame end commits whatever the frame asked for
                if (cs_rise) begin
                    if (cur.got_dpd) begin
                        next_cur.power = sn_sleep_pkg::st_enter_dpd;
                        next_cur.timer = 16'h0000;
                    end else if (cur.got_hib) begin
                        next_cur.power = sn_sleep_pkg::st_enter_hib;
                        next_cur.timer = 16'h0000;
                    end
                end
            end
            sn_sleep_pkg::st_enter_dpd: begin
                next_cur.timer = cur.timer + 16'h0001;
                // entry takes the full limit of 60 cycles; select is ignored meanwhile
                if (cur.timer >= 16'(sn_sleep_pkg::deep_sleep_entry_cycles - 1)) begin
                    next_cur.power = sn_sleep_pkg::st_dpd;
                end
            end
            sn_sleep_pkg::st_dpd: begin
                // count select-low width; sck and si play no part
                if (cs_b) begin
                    next_cur.timer = 16'h0000;
                end else begin
                    next_cur.timer = cur.timer + 16'h0001;
                    if (cur.timer >= 16'(sn_sleep_pkg::deep_sleep_wake_cycles - 1)) begin
                        next_cur.power = sn_sleep_pkg::st_exit_dpd;
                        next_cur.timer = 16'h0000;
                    end
                end
            end
            sn_sleep_pkg::st_exit_dpd: begin
                next_cur.timer = cur.timer + 16'h0001;
                if (cur.timer >= 16'(sn_sleep_pkg::deep_sleep_exit_cycles - 2)) begin
                    next_cur.power = sn_sleep_pkg::st_awake;
                end
            end
            sn_sleep_pkg::st_enter_hib: begin
                next_cur.timer = cur.timer + 16'h0001;
                if (cur.timer >= 16'(sn_sleep_pkg::hibernate_entry_cycles - 1)) begin
                    next_cur.power = sn_sleep_pkg::st_hib;
                end
            end
            sn_sleep_pkg::st_hib: begin
                if (cs_fall) begin
                    next_cur.power = sn_sleep_pkg::st_exit_hib;
                    next_cur.timer = 16'h0000;
                end
            end
            sn_sleep_pkg::st_exit_hib: begin
                next_cur.timer = cur.timer + 16'h0001;
                if (cur.timer >= 16'(hib_exit_cycles - 1)) begin
                    next_cur.power = sn_sleep_pkg::st_awake;
                end
            end
        endcase

        // ====================================================================
        // command shifter, live only while awake
        if (cur.power != sn_sleep_pkg::st_awake || cs_b) begin
            next_cur.phase    = sn_sleep_pkg::op_opcode;
            next_cur.bit_cnt  = 3'd0;
            next_cur.byte_cnt = 3'd0;
        end
        if (cur.power != sn_sleep_pkg::st_awake) begin
            next_cur.got_dpd   = 1'b0;
            next_cur.got_hib   = 1'b0;
            next_cur.prog_full = 1'b0;
        end else if (cs_fall) begin
            next_cur.got_dpd   = 1'b0;
            next_cur.got_hib   = 1'b0;
            next_cur.prog_full = 1'b0;
        end else if (cs_rise) begin
            // program lands only on a frame end after all eight bytes
            if (cur.prog_full) begin
                next_cur.board_serial_number = cur.staged;
                next_cur.write_permit        = 1'b0;
            end
            next_cur.prog_full = 1'b0;
        end else if (sck_rise) begin
            next_cur.shift   = shifted;
            next_cur.bit_cnt = cur.bit_cnt + 3'd1;
            if (cur.bit_cnt == 3'd7) begin
                unique case (cur.phase)
                    sn_sleep_pkg::op_opcode: begin
                        next_cur.phase = sn_sleep_pkg::op_ignore;
                        if (shifted == sn_sleep_pkg::write_permit_cmd) begin
                            next_cur.write_permit = 1'b1;
                        end else if (shifted == sn_sleep_pkg::serial_id_program_cmd) begin
                            // without a permit the frame is dropped
                            if (cur.write_permit) begin
                                next_cur.phase = sn_sleep_pkg::op_program;
                            end
                        end else if (shifted == sn_sleep_pkg::serial_id_fetch_cmd) begin
                            next_cur.phase = sn_sleep_pkg::op_fetch;
                        end else if (shifted == sn_sleep_pkg::deep_sleep_cmd) begin
                            next_cur.got_dpd = 1'b1;
                        end else if (shifted == sn_sleep_pkg::hibernate_cmd) begin
                            next_cur.got_hib = 1'b1;
                        end
                    end
                    sn_sleep_pkg::op_program: begin
                        // bytes arrive least significant first, msb-first within each
                        next_cur.staged[{cur.byte_cnt, 3'b000} +: 8] = shifted;
                        next_cur.byte_cnt = cur.byte_cnt + 3'd1;
                        if (cur.byte_cnt == 3'd7) begin
                            next_cur.prog_full = 1'b1;
                            next_cur.phase     = sn_sleep_pkg::op_ignore;
                        end
                    end
                    sn_sleep_pkg::op_fetch: begin
                        // 3-bit counter wraps byte 7 back to byte 0
                        next_cur.byte_cnt = cur.byte_cnt + 3'd1;
                    end
                    sn_sleep_pkg::op_ignore: begin
                    end
                endcase
            end
        end

        // ====================================================================
        // serial output, driven on sck fall during a fetch
        if (cur.power != sn_sleep_pkg::st_awake || cs_b) begin
            next_cur.so    = 1'b0;
            next_cur.so_oe = 1'b0;
        end else if (sck_fall && cur.phase == sn_sleep_pkg::op_fetch) begin
            next_cur.so_oe = 1'b1;
            next_cur.so    = fetch_byte[3'd7 - cur.bit_cnt];
        end
        next_cur.asleep = next_cur.power != sn_sleep_pkg::st_awake;
    end

    // ========================================================================
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            cur                     <= '0;
            cur.sync1               <= 3'b100;
            cur.sync2               <= 3'b100;
            cur.prev                <= 3'b100;
            cur.power               <= sn_sleep_pkg::st_awake;
            cur.phase               <= sn_sleep_pkg::op_opcode;
            cur.board_serial_number <= sn_sleep_pkg::sn_reset;
        end else begin
            cur <= next_cur;
        end
    end

    assign spi_out.so          = cur.so;
    assign spi_out.so_oe       = cur.so_oe;
    assign asleep              = cur.asleep;
    assign board_serial_number = cur.board_serial_number;

endmodule

//--- logic/sn_sleep_pkg.sv
// constants and carrier types for the serial-number and low-power command block
// assumes a single 20 MHz system clock; spi pins arrive asynchronously
package sn_sleep_pkg;

    // opcodes
    localparam logic [7:0] write_permit_cmd      = 8'h06;
    localparam logic [7:0] serial_id_program_cmd = 8'hC2;
    localparam logic [7:0] serial_id_fetch_cmd   = 8'hC3;
    localparam logic [7:0] deep_sleep_cmd        = 8'hBA;
    localparam logic [7:0] hibernate_cmd         = 8'hB9;

    localparam int          sn_bytes     = 8;
    localparam logic [63:0] sn_reset     = 64'h0000_0000_0000_0000;

    // timing, in ns, and derived cycle counts at the system clock
    localparam int clk_period_ns                = 50;
    localparam int deep_sleep_entry_delay_ns    = 3000;
    localparam int deep_sleep_wake_pulse_ns     = 15;
    localparam int deep_sleep_exit_delay_ns     = 10000;
    localparam int hibernate_entry_delay_ns     = 3000;
    localparam int hibernate_exit_delay_ns      = 450000;

    // longest times round down, least times round up, never below one
    localparam int deep_sleep_entry_cycles =
        (deep_sleep_entry_delay_ns / clk_period_ns) < 1 ? 1 :
        (deep_sleep_entry_delay_ns / clk_period_ns);
    localparam int deep_sleep_wake_cycles =
        ((deep_sleep_wake_pulse_ns + clk_period_ns - 1) / clk_period_ns) < 1 ? 1 :
        ((deep_sleep_wake_pulse_ns + clk_period_ns - 1) / clk_period_ns);
    localparam int deep_sleep_exit_cycles =
        (deep_sleep_exit_delay_ns / clk_period_ns) < 1 ? 1 :
        (deep_sleep_exit_delay_ns / clk_period_ns);
    localparam int hibernate_entry_cycles =
        (hibernate_entry_delay_ns / clk_period_ns) < 1 ? 1 :
        (hibernate_entry_delay_ns / clk_period_ns);
    localparam int hibernate_exit_cycles_doc = hibernate_exit_delay_ns / clk_period_ns;

    typedef enum {
        st_awake, st_enter_dpd, st_dpd, st_exit_dpd,
        st_enter_hib, st_hib, st_exit_hib
    } power_type;

    typedef enum {
        op_opcode, op_program, op_fetch, op_ignore
    } phase_type;

    typedef struct packed {
        logic cs_b;
        logic sck;
        logic si;
    } spi_in_type;

    typedef struct packed {
        logic so;
        logic so_oe;
    } spi_out_type;

endpackage
